// ===== inc/flag_and_load_store_ops_cfg.svh
// How it works
// - Raise and drop commands set or clear any one of carry, negative, zero, bit-store and half-carry in one cycle, touching no other flag.
// - The overflow flag has its own raise and drop commands of one cycle that leave every other flag alone.
// - The signed test flag is raised or dropped by a one-cycle command that changes no other status bit.
// - The global interrupt enable flag is raised or dropped in one cycle and is driven out to gate interrupt acceptance.
// - A post-increment indirect read loads the byte at the pointer into the destination and then adds one to the pointer, in two cycles, flags untouched.
// - A pre-decrement indirect read first subtracts one from the pointer and then loads the byte at the new value, in two cycles, flags untouched.
// - An offset read exists only for the second and third pointers and loads the byte at pointer plus unsigned offset in two cycles, pointer unchanged.
// - An absolute read loads the byte at the address carried by the command into the destination in two cycles, flags untouched.
// - A plain or post-increment indirect write stores the source at the pointer, the latter then adding one to the pointer, in two cycles, flags untouched.
// - A pre-decrement indirect write subtracts one from the pointer and then stores the source at the new value, in two cycles, flags untouched.
`ifndef FLAG_AND_LOAD_STORE_OPS_CFG_SVH
`define FLAG_AND_LOAD_STORE_OPS_CFG_SVH

`define FLAG_CARRY       3'h0
`define FLAG_ZERO        3'h1
`define FLAG_NEGATIVE    3'h2
`define FLAG_OVERFLOW    3'h3
`define FLAG_SIGN        3'h4
`define FLAG_HALFCARRY   3'h5
`define FLAG_BITSTORE    3'h6
`define FLAG_IRQ_ENABLE  3'h7
`define FLAGS_RESET      8'h00
`define REGS_RESET       8'h00

`define PTR_X_LOW        5'h1A
`define PTR_Y_LOW        5'h1C
`define PTR_Z_LOW        5'h1E

`define DATA_W           8
`define ADDR_W           16
`define REG_COUNT        32
`define DISP_W           6

`endif

// ===== inc/flag_and_load_store_ops_pkg.sv
`include "flag_and_load_store_ops_cfg.svh"

package flag_and_load_store_ops_pkg;

	typedef enum logic [3:0] {
		op_none,
		op_flag_raise,
		op_flag_drop,
		register_copy,
		register_pair_copy,
		immediate_load,
		indirect_read,
		offset_read,
		absolute_read,
		indirect_write
	} op_type;

	typedef enum logic [1:0] {
		ptr_x,
		ptr_y,
		ptr_z
	} ptr_sel_type;

	typedef enum logic [1:0] {
		ptr_plain,
		ptr_post_inc,
		ptr_pre_dec,
		ptr_disp
	} ptr_mode_type;

	typedef enum logic [1:0] {
		st_idle,
		st_read,
		st_write
	} state_type;

endpackage

// ===== hw/pointer_step.sv
`timescale 1ns/100ps
`default_nettype none
`include "flag_and_load_store_ops_cfg.svh"

module pointer_step
	import flag_and_load_store_ops_pkg::*;
#(
	parameter int ADDR_W = `ADDR_W,
	parameter int DISP_W = `DISP_W
) (
	input  wire logic [ADDR_W-1:0] ptr_i,
	input  wire ptr_mode_type      mode_i,
	input  wire logic [DISP_W-1:0] disp_i,
	output logic      [ADDR_W-1:0] access_addr_o,
	output logic      [ADDR_W-1:0] next_ptr_o
);

	logic [ADDR_W-1:0] inc;
	logic [ADDR_W-1:0] dec;
	logic [ADDR_W-1:0] offs;

	// Sums are cut to the pointer width so they wrap
	assign inc  = ADDR_W'(ptr_i + 1'b1);
	assign dec  = ADDR_W'(ptr_i - 1'b1);
	assign offs = ADDR_W'(ptr_i + {{(ADDR_W-DISP_W){1'b0}}, disp_i});

	always_comb begin
		access_addr_o = ptr_i;
		next_ptr_o    = ptr_i;
		case (mode_i)
			ptr_plain: begin
				access_addr_o = ptr_i;
			end
			ptr_post_inc: begin
				next_ptr_o = inc;
			end
			ptr_pre_dec: begin
				access_addr_o = dec;
				next_ptr_o    = dec;
			end
			ptr_disp: begin
				access_addr_o = offs;
			end
			default: begin
				access_addr_o = ptr_i;
			end
		endcase
	end

endmodule

`default_nettype wire

// ===== hw/flag_and_load_store_ops.sv
`timescale 1ns/100ps
`default_nettype none
`include "flag_and_load_store_ops_cfg.svh"

module flag_and_load_store_ops
	import flag_and_load_store_ops_pkg::*;
#(
	parameter int DATA_W    = `DATA_W,
	parameter int ADDR_W    = `ADDR_W,
	parameter int REG_COUNT = `REG_COUNT,
	parameter int DISP_W    = `DISP_W
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              cmd_valid_i,
	output logic                   cmd_ready_o,
	input  wire op_type            cmd_op_i,
	input  wire logic [2:0]        cmd_flag_i,
	input  wire logic [4:0]        cmd_dst_i,
	input  wire logic [4:0]        cmd_src_i,
	input  wire logic [DATA_W-1:0] cmd_imm_i,
	input  wire logic [ADDR_W-1:0] cmd_addr_i,
	input  wire ptr_sel_type       cmd_ptr_i,
	input  wire ptr_mode_type      cmd_mode_i,
	input  wire logic [DISP_W-1:0] cmd_disp_i,
	output logic                   done_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic [DATA_W-1:0]      mem_wdata_o,
	output logic                   mem_re_o,
	output logic                   mem_we_o,
	input  wire logic [DATA_W-1:0] mem_rdata_i,
	output logic [7:0]             flags_o,
	output logic                   irq_enable_o,
	input  wire logic [4:0]        reg_rd_addr_i,
	output logic [DATA_W-1:0]      reg_rd_data_o
);

	typedef struct packed {
		state_type                     state;
		logic [7:0]                    flags;
		logic [REG_COUNT-1:0][DATA_W-1:0] regs;
		logic [ADDR_W-1:0]             mem_addr;
		logic [DATA_W-1:0]             mem_wdata;
		logic                          mem_re;
		logic                          mem_we;
		logic [4:0]                    load_dst;
		logic                          done;
	} core_state_type;

	core_state_type    cur;
	core_state_type    next_cur;
	logic [4:0]        ptr_low;
	logic [ADDR_W-1:0] ptr_value;
	ptr_mode_type      step_mode;
	logic [ADDR_W-1:0] access_addr;
	logic [ADDR_W-1:0] next_ptr;
	logic              take;
	logic              disp_ok;
	logic [4:0]        ptr_high;
	logic [7:0]        flag_bit;

	assign cmd_ready_o   = (cur.state == st_idle);
	assign take          = cmd_valid_i && cmd_ready_o;
	assign done_o        = cur.done;
	assign mem_addr_o    = cur.mem_addr;
	assign mem_wdata_o   = cur.mem_wdata;
	assign mem_re_o      = cur.mem_re;
	assign mem_we_o      = cur.mem_we;
	assign flags_o       = cur.flags;
	assign irq_enable_o  = cur.flags[`FLAG_IRQ_ENABLE];
	assign reg_rd_data_o = cur.regs[reg_rd_addr_i];

	// Pointer pair is the low register and the one above it
	always_comb begin
		case (cmd_ptr_i)
			ptr_x:   ptr_low = `PTR_X_LOW;
			ptr_y:   ptr_low = `PTR_Y_LOW;
			ptr_z:   ptr_low = `PTR_Z_LOW;
			default: ptr_low = `PTR_Z_LOW;
		endcase
	end

	assign ptr_high  = 5'(ptr_low + 5'h01);
	assign ptr_value = {cur.regs[ptr_high], cur.regs[ptr_low]};

	// Offset reads always add the offset; indirect ops take it as plain
	always_comb begin
		case (cmd_op_i)
			offset_read: begin
				step_mode = ptr_disp;
			end
			indirect_read, indirect_write: begin
				step_mode = (cmd_mode_i == ptr_disp) ? ptr_plain : cmd_mode_i;
			end
			default: begin
				step_mode = ptr_plain;
			end
		endcase
	end

	// One-hot mask of the addressed flag, so the other seven hold
	always_comb begin
		flag_bit             = 8'h00;
		flag_bit[cmd_flag_i] = 1'b1;
	end

	// No offset form exists on the first pointer
	assign disp_ok   = (cmd_ptr_i != ptr_x);

	pointer_step #(
		.ADDR_W (ADDR_W),
		.DISP_W (DISP_W)
	) u_pointer_step (
		.ptr_i         (ptr_value),
		.mode_i        (step_mode),
		.disp_i        (cmd_disp_i),
		.access_addr_o (access_addr),
		.next_ptr_o    (next_ptr)
	);

	always_comb begin
		next_cur        = cur;
		next_cur.done   = 1'b0;
		next_cur.mem_re = 1'b0;
		next_cur.mem_we = 1'b0;
		case (cur.state)
			st_idle: begin
				if (take) begin
					case (cmd_op_i)
						op_flag_raise: begin
							// Only the masked bit moves
							next_cur.flags = cur.flags | flag_bit;
							next_cur.done = 1'b1;
						end
						op_flag_drop: begin
							next_cur.flags = cur.flags & ~flag_bit;
							next_cur.done = 1'b1;
						end
						register_copy: begin
							next_cur.regs[cmd_dst_i] = cur.regs[cmd_src_i];
							next_cur.done = 1'b1;
						end
						register_pair_copy: begin
							// Even-aligned pair, low bit of each index ignored
							next_cur.regs[{cmd_dst_i[4:1], 1'b0}] =
								cur.regs[{cmd_src_i[4:1], 1'b0}];
							next_cur.regs[{cmd_dst_i[4:1], 1'b1}] =
								cur.regs[{cmd_src_i[4:1], 1'b1}];
							next_cur.done = 1'b1;
						end
						immediate_load: begin
							next_cur.regs[cmd_dst_i] = cmd_imm_i;
							next_cur.done = 1'b1;
						end
						indirect_read: begin
							next_cur.mem_addr = access_addr;
							next_cur.mem_re   = 1'b1;
							next_cur.load_dst = cmd_dst_i;
							next_cur.regs[ptr_low]  = next_ptr[7:0];
							next_cur.regs[ptr_high] = next_ptr[15:8];
							next_cur.state    = st_read;
						end
						offset_read: begin
							if (disp_ok) begin
								next_cur.mem_addr = access_addr;
								next_cur.mem_re   = 1'b1;
								next_cur.load_dst = cmd_dst_i;
								next_cur.state    = st_read;
							end else begin
								next_cur.done = 1'b1;
							end
						end
						absolute_read: begin
							next_cur.mem_addr = cmd_addr_i;
							next_cur.mem_re   = 1'b1;
							next_cur.load_dst = cmd_dst_i;
							next_cur.state    = st_read;
						end
						indirect_write: begin
							next_cur.mem_addr  = access_addr;
							next_cur.mem_wdata = cur.regs[cmd_src_i];
							next_cur.mem_we    = 1'b1;
							next_cur.regs[ptr_low]  = next_ptr[7:0];
							next_cur.regs[ptr_high] = next_ptr[15:8];
							next_cur.state     = st_write;
						end
						default: begin
							next_cur.done = 1'b1;
						end
					endcase
				end
			end
			st_read: begin
				// Second cycle: memory answers in the cycle the address stands
				next_cur.regs[cur.load_dst] = mem_rdata_i;
				next_cur.done  = 1'b1;
				next_cur.state = st_idle;
			end
			st_write: begin
				next_cur.done  = 1'b1;
				next_cur.state = st_idle;
			end
			default: begin
				next_cur.state = st_idle;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cur.state     <= st_idle;
			cur.flags     <= `FLAGS_RESET;
			cur.regs      <= {REG_COUNT{`REGS_RESET}};
			cur.mem_addr  <= '0;
			cur.mem_wdata <= '0;
			cur.mem_re    <= 1'b0;
			cur.mem_we    <= 1'b0;
			cur.load_dst  <= 5'h00;
			cur.done      <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

`default_nettype wire

// ===== bench/flag_and_load_store_ops_sva.sv
`timescale 1ns/100ps
`default_nettype none
module flag_and_load_store_ops_chk
	import flag_and_load_store_ops_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        cmd_valid_i,
	input wire logic        cmd_ready_o,
	input wire op_type      cmd_op_i,
	input wire logic [2:0]  cmd_flag_i,
	input wire logic [15:0] cmd_addr_i,
	input wire ptr_sel_type cmd_ptr_i,
	input wire logic        done_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_re_o,
	input wire logic        mem_we_o,
	input wire logic [7:0]  flags_o,
	input wire logic        irq_enable_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic tk = cmd_valid_i && cmd_ready_o;
	wire logic mtk = tk && (cmd_op_i inside {indirect_read, absolute_read,
		indirect_write} || (cmd_op_i == offset_read && cmd_ptr_i != ptr_x));
	sequence s_busy; !cmd_ready_o && !done_o; endsequence
	sequence s_end; done_o && cmd_ready_o; endsequence
	property p_raise;
		tk && cmd_op_i == op_flag_raise |=> done_o &&
			flags_o == ($past(flags_o) | (8'h01 << $past(cmd_flag_i)));
	endproperty
	a_raise: assert property (p_raise)
		else $error("flag raise wrong");
	property p_drop;
		tk && cmd_op_i == op_flag_drop |=> done_o &&
			flags_o == ($past(flags_o) & ~(8'h01 << $past(cmd_flag_i)));
	endproperty
	a_drop: assert property (p_drop)
		else $error("flag drop wrong");
	property p_irq;
		irq_enable_o == flags_o[7];
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq enable wrong");
	property p_irq_hold;
		!(tk && cmd_op_i inside {op_flag_raise, op_flag_drop} &&
			cmd_flag_i == 3'h7) |=> $stable(irq_enable_o);
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq enable moved");
	property p_memseq;
		mtk |=> s_busy ##1 s_end;
	endproperty
	a_memseq: assert property (p_memseq)
		else $error("mem op timing");
	property p_memflags;
		mtk |=> $stable(flags_o) ##1 $stable(flags_o);
	endproperty
	a_memflags: assert property (p_memflags)
		else $error("flags moved");
	property p_abs;
		tk && cmd_op_i == absolute_read |=> mem_re_o && !mem_we_o &&
			mem_addr_o == $past(cmd_addr_i);
	endproperty
	a_abs: assert property (p_abs)
		else $error("absolute read wrong");
	property p_wr;
		tk && cmd_op_i == indirect_write |=> mem_we_o && !mem_re_o ##1 !mem_we_o;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write strobe wrong");
	property p_one;
		tk && cmd_op_i inside {register_copy, register_pair_copy, immediate_load}
			|=> done_o && cmd_ready_o && $stable(flags_o);
	endproperty
	a_one: assert property (p_one)
		else $error("one cycle op wrong");
	property p_offx;
		tk && cmd_op_i == offset_read && cmd_ptr_i == ptr_x |=> done_o && !mem_re_o;
	endproperty
	a_offx: assert property (p_offx)
		else $error("offset on first pointer");
endmodule
bind flag_and_load_store_ops flag_and_load_store_ops_chk u_chk (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_flag_i(cmd_flag_i),
	.cmd_addr_i(cmd_addr_i), .cmd_ptr_i(cmd_ptr_i), .done_o(done_o),
	.mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
	.flags_o(flags_o), .irq_enable_o(irq_enable_o));
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
	import flag_and_load_store_ops_pkg::*;
;
	logic sys_clk_i = 0, rst_n_i = 0, valid = 0, re = 0, we = 0;
	op_type op = op_none;
	ptr_sel_type p = ptr_x;
	ptr_mode_type m = ptr_plain;
	logic [4:0] d = 5'h00, rd = 5'h00;
	logic [15:0] v = 16'h0000, ma = 16'h0000, lat = 16'h0000;
	logic [7:0] wd = 8'h00;
	logic rdy1 = 1'b0;
	logic ready, done, mre, mwe, irq;
	logic [15:0] maddr;
	logic [7:0] wdat, flags, rdo;
	int n_errors = 0, n_tests = 0;
	// Read data only valid under the strobe; otherwise an inverted pattern
	wire logic [7:0] rdat = mre ? maddr[7:0] ^ 8'hA5 : ~(maddr[7:0] ^ 8'hA5);
	always #2 sys_clk_i = ~sys_clk_i;
	flag_and_load_store_ops DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_op_i(op),
		.cmd_flag_i(v[2:0]), .cmd_dst_i(d), .cmd_src_i(v[4:0]),
		.cmd_imm_i(v[7:0]), .cmd_addr_i(v), .cmd_ptr_i(p), .cmd_mode_i(m),
		.cmd_disp_i(v[5:0]), .done_o(done), .mem_addr_o(maddr),
		.mem_wdata_o(wdat), .mem_re_o(mre), .mem_we_o(mwe),
		.mem_rdata_i(rdat), .flags_o(flags), .irq_enable_o(irq),
		.reg_rd_addr_i(rd), .reg_rd_data_o(rdo));
	task finish_test;
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rg(input logic [4:0] i, input logic [7:0] e);
		rd = i;
		#0.1;
		chk({8'h00, rdo}, {8'h00, e});
	endtask
	task run(input op_type o, input ptr_sel_type pp, input ptr_mode_type mm,
		input logic [4:0] dd, input logic [15:0] vv);
		int k;
		op = o; p = pp; m = mm; d = dd; v = vv; valid = 1; re = 0; we = 0;
		@(posedge sys_clk_i);
		#1 valid = 0;
		for (k = 1; k < 5; k++) begin
			if (k == 1) rdy1 = ready;
			if ((mre | mwe) === 1'b1) begin
				re = mre; we = mwe; ma = maddr; wd = wdat;
			end
			if (done === 1'b1) break;
			@(posedge sys_clk_i);
			#1;
		end
		lat = 16'(k);
		if (k == 5) begin
			n_errors++;
			finish_test();
		end
		// An idle edge keeps the next request out of this time step
		@(posedge sys_clk_i);
		#1;
	endtask
	task mchk(input logic [15:0] a, input logic w);
		chk(lat, 16'h0002);
		chk({15'h0000, rdy1}, 16'h0000);
		chk(ma, a);
		chk({14'h0000, re, we}, {14'h0000, !w, w});
		chk({8'h00, flags}, 16'h0080);
	endtask
	task t_reset;
		chk({8'h00, flags}, 16'h0000);
		rg(5'h1A, 8'h00);
	endtask
	task t_flags;
		logic [7:0] e;
		e = 8'h00;
		// Raise all eight, then drop all but the interrupt enable
		for (int k = 0; k < 15; k++) begin
			run(k < 8 ? op_flag_raise : op_flag_drop, ptr_x, ptr_plain, 5'h00,
				16'(k % 8));
			e[k % 8] = k < 8;
			chk({8'h00, flags}, {8'h00, e});
			chk(lat, 16'h0001);
			chk({15'h0000, rdy1}, 16'h0001);
			chk({15'h0000, irq}, {15'h0000, e[7]});
		end
	endtask
	task t_moves;
		logic [7:0] ini [7];
		ini = '{8'hFF, 8'hFF, 8'h10, 8'h00, 8'h00, 8'h00, 8'hC3};
		for (int k = 0; k < 7; k++) begin
			run(immediate_load, ptr_x, ptr_plain, k < 6 ? 5'(26 + k) : 5'h05,
				{8'h00, ini[k]});
			chk(lat, 16'h0001);
			rg(k < 6 ? 5'(26 + k) : 5'h05, ini[k]);
		end
		run(register_copy, ptr_x, ptr_plain, 5'h01, 16'h0005);
		chk(lat, 16'h0001);
		rg(5'h01, 8'hC3);
		run(register_pair_copy, ptr_x, ptr_plain, 5'h02, 16'h001C);
		chk(lat, 16'h0001);
		rg(5'h02, 8'h10);
		rg(5'h03, 8'h00);
		chk({8'h00, flags}, 16'h0080);
	endtask
	task t_reads;
		run(indirect_read, ptr_x, ptr_post_inc, 5'h07, 16'h0000);
		mchk(16'hFFFF, 0);
		rg(5'h07, 8'h5A);
		rg(5'h1A, 8'h00);
		rg(5'h1B, 8'h00);
		run(indirect_read, ptr_z, ptr_pre_dec, 5'h08, 16'h0000);
		mchk(16'hFFFF, 0);
		rg(5'h08, 8'h5A);
		rg(5'h1F, 8'hFF);
		run(offset_read, ptr_y, ptr_disp, 5'h09, 16'h003F);
		mchk(16'h004F, 0);
		rg(5'h09, 8'hEA);
		rg(5'h1C, 8'h10);
		run(offset_read, ptr_x, ptr_disp, 5'h0A, 16'h0001);
		chk(lat, 16'h0001);
		rg(5'h0A, 8'h00);
		run(absolute_read, ptr_x, ptr_plain, 5'h0B, 16'h1234);
		mchk(16'h1234, 0);
		rg(5'h0B, 8'h91);
		run(indirect_read, ptr_y, ptr_plain, 5'h0C, 16'h0000);
		mchk(16'h0010, 0);
		rg(5'h0C, 8'hB5);
		rg(5'h1C, 8'h10);
	endtask
	task t_writes;
		run(indirect_write, ptr_y, ptr_post_inc, 5'h00, 16'h0005);
		mchk(16'h0010, 1);
		chk({8'h00, wd}, 16'h00C3);
		rg(5'h1C, 8'h11);
		run(indirect_write, ptr_y, ptr_pre_dec, 5'h00, 16'h0002);
		mchk(16'h0010, 1);
		chk({8'h00, wd}, 16'h0010);
		run(indirect_write, ptr_z, ptr_plain, 5'h00, 16'h0001);
		mchk(16'hFFFF, 1);
		rg(5'h1E, 8'hFF);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		#1 rst_n_i = 1;
		@(posedge sys_clk_i);
		#1;
		t_reset();
		t_flags();
		t_moves();
		t_reads();
		t_writes();
		finish_test();
	end
endmodule
`default_nettype wire
